// *** scp_pkg.sv ***
`default_nettype none

package scp_pkg;

    // ==========================================================
    // Frame layout
    // ==========================================================
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h01;
    localparam logic [CNT_W-1:0] CNT_CODE_LAST = 5'h06;
    localparam logic [CNT_W-1:0] CNT_INSTR_LAST = 5'h07;
    localparam logic [CNT_W-1:0] CNT_DATA_FIRST = 5'h08;
    localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [CNT_W-1:0] CNT_ADDR_BITS = 5'h02;
    localparam logic [1:0] CHIP_ADDR = 2'h0;

    // ==========================================================
    // Verification byte and answer bytes
    // ==========================================================
    localparam logic [1:0] VERIF_Z_BITS = 2'h0;
    localparam logic [4:0] VERIF_PATTERN = 5'h15;
    localparam logic [7:0] BYTE_INVALID = 8'hFF;
    localparam logic [7:0] BYTE_WRITE = 8'h00;
    localparam logic TRANS_FLAG_RST = 1'b0;

    // ==========================================================
    // Instruction map
    // ==========================================================
    localparam logic [4:0] CODE_READ_LAST = 5'h0F;
    localparam logic [4:0] CODE_WRITE_FIRST = 5'h11;
    localparam logic [4:0] CODE_WRITE_LAST = 5'h17;
    localparam logic [4:0] CODE_CLEAR_DIAG = 5'h18;
    localparam logic [4:0] CODE_DIAG_FIRST = 5'h08;
    localparam logic [4:0] CODE_DIAG_LAST = 5'h0C;

    typedef enum logic [1:0] {
        CLS_NONE = 2'h0,
        CLS_READ = 2'h1,
        CLS_WRITE = 2'h3,
        CLS_CLEAR = 2'h2
    } scp_class_e;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int SPI_MIN_PERIOD_NS = 200;
    localparam int SCK_HALF_CYC =
        (SPI_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int SYNC_STAGES = 3;

    // ==========================================================
    // Host command registers
    // ==========================================================
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TXDATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_BADPAR_BIT = 5;
    localparam int CTRL_NBITS_LSB = 6;
    localparam int CTRL_START_BIT = 31;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CLRDUE_BIT = 1;
    localparam int STAT_VERIF_LSB = 8;
    localparam int STAT_RXD_LSB = 16;
    localparam logic [4:0] NBITS_RST = 5'h10;
    localparam logic [4:0] CODE_RST = 5'h00;
    localparam logic [7:0] TXDATA_RST = 8'h00;

    function automatic scp_class_e scp_decode(input logic [4:0] code);
        scp_class_e c;
        c = CLS_NONE;
        if (code <= CODE_READ_LAST) begin
            c = CLS_READ;
        end else if (code >= CODE_WRITE_FIRST && code <= CODE_WRITE_LAST) begin
            c = CLS_WRITE;
        end else if (code == CODE_CLEAR_DIAG) begin
            c = CLS_CLEAR;
        end
        return c;
    endfunction : scp_decode

    function automatic logic scp_parity(input logic [4:0] code);
        return ^code;
    endfunction : scp_parity

endpackage : scp_pkg

`default_nettype wire

// *** scp_spi_if.sv ***
`default_nettype none

interface scp_spi_if;
    logic sel_b;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_b;

    modport device (
        input sel_b,
        input sck,
        input mosi,
        output miso,
        output miso_oe_b
    );

    modport host (
        output sel_b,
        output sck,
        output mosi,
        input miso
    );
endinterface : scp_spi_if

`default_nettype wire

// *** scp_device.sv ***
//Behaviour
// RQ1 - Slave only; host clocks, at most 5 MBaud
// RQ2 - Answer only when selected and address 00
// RQ3 - Serial output floats while deselected
// RQ4 - Instruction first; data bytes MSB first
// RQ5 - Bits 5..1 code, bit 0 parity
// RQ6 - Deselect returns serial logic to idle
// RQ7 - 5V reset floats output; shutoff ignored
// RQ8 - Verification byte: Z Z 1 0 1 0 1 flag
// RQ9 - Error flag kept until shifted out
// RQ10 - Serial input ignored after read instruction
// RQ11 - Write or clear answers low afterwards
// RQ12 - Bits after the sixteenth are discarded
// RQ13 - Invalid on bad code, busy, count
// RQ14 - Commit only with exactly sixteen falling edges
// RQ15 - Clock high at deselect cancels write
// RQ16 - Invalid code: no change, answer FFh
// RQ17 - Valid read returns register despite parity
// RQ18 - Write answers 00h, commits on good parity
// RQ19 - Foreign chip address keeps device passive
// RQ20 - Output floats during chip address bits
// RQ21 - Code 11000 clears fault-status registers
// RQ22 - Decode read, write and no-function codes
// RQ23 - Host clears faults after reading them
// RQ24 - Parity is XOR of five code bits
`default_nettype none

module scp_device (
    input wire logic clk_sys,
    input wire logic rst_b,
    scp_spi_if.device spi,
    input wire logic reset_5v_b,
    input wire logic proc_busy,
    input wire logic [7:0] rd_data,
    output logic [4:0] reg_code,
    output logic wr_stb,
    output logic [4:0] wr_code,
    output logic [7:0] wr_data,
    output logic clr_stb,
    output logic err_flag
);
    import scp_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int I_MOSI = 0;
    localparam int I_SCK = 1;
    localparam int I_SEL = 2;
    localparam int I_RST5 = 3;
    localparam logic [3:0] SYNC_RST = 4'hC;

    logic [3:0] raw;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] filt_q;
    logic [3:0] prev_q;

    assign raw = {reset_5v_b, spi.sel_b, spi.sck, spi.mosi};

    // A change counts only once stages two and three agree, which
    // rejects single-sample glitches on the pins.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q[gi] <= SYNC_RST[gi];
                    s2_q[gi] <= SYNC_RST[gi];
                    s3_q[gi] <= SYNC_RST[gi];
                    filt_q[gi] <= SYNC_RST[gi];
                    prev_q[gi] <= SYNC_RST[gi];
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                    prev_q[gi] <= filt_q[gi];
                end
            end
        end
    endgenerate

    logic sel_act;
    logic sel_rise;
    logic sel_fall;
    logic sck_rise;
    logic sck_fall;
    logic rst5_act;
    logic mosi_f;

    assign sel_act = ~filt_q[I_SEL];
    assign sel_rise = filt_q[I_SEL] & ~prev_q[I_SEL];
    assign sel_fall = ~filt_q[I_SEL] & prev_q[I_SEL];
    assign sck_rise = filt_q[I_SCK] & ~prev_q[I_SCK];
    assign sck_fall = ~filt_q[I_SCK] & prev_q[I_SCK];
    assign rst5_act = ~filt_q[I_RST5];
    assign mosi_f = filt_q[I_MOSI];

    // ==========================================================
    // Receive side
    // ==========================================================
    logic [CNT_W-1:0] cnt_q;
    logic [FRAME_BITS-1:0] shin_q;
    logic addr_ok_q;
    logic [7:0] instr_q;
    scp_class_e cls_q;
    logic [4:0] reg_code_q;
    logic busy_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            shin_q <= '0;
        end else if (!sel_act) begin
            cnt_q <= '0; // RQ6
            shin_q <= '0;
        end else if (sck_fall) begin
            if (cnt_q != CNT_MAX) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (cnt_q < CNT_FRAME) begin // RQ12
                shin_q <= {shin_q[FRAME_BITS-2:0], mosi_f}; // RQ4
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_ok_q <= 1'b0;
            instr_q <= '0;
            cls_q <= CLS_NONE;
            reg_code_q <= CODE_RST;
        end else if (!sel_act) begin
            addr_ok_q <= 1'b0;
            cls_q <= CLS_NONE;
        end else if (sck_fall) begin
            if (cnt_q == CNT_ADDR_LAST) begin
                addr_ok_q <= ({shin_q[0], mosi_f} == CHIP_ADDR); // RQ2 RQ19
            end
            if (cnt_q == CNT_CODE_LAST) begin
                reg_code_q <= {shin_q[3:0], mosi_f}; // RQ5
                cls_q <= scp_decode({shin_q[3:0], mosi_f}); // RQ22
            end
            if (cnt_q == CNT_INSTR_LAST) begin
                instr_q <= {shin_q[6:0], mosi_f};
            end
        end
    end

    // Busy is judged at selection: the previous transfer must be
    // fully processed before this one may count as valid.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else if (sel_fall) begin
            busy_q <= proc_busy; // RQ13
        end
    end

    // ==========================================================
    // Transmit side
    // ==========================================================
    logic out_q;
    logic oe_b_q;
    logic sent_q;
    logic flag_q;
    logic [7:0] tx_q;
    logic [7:0] verif_byte;
    logic [7:0] data_byte;

    assign verif_byte = {VERIF_Z_BITS, VERIF_PATTERN, flag_q}; // RQ8

    always_comb begin
        data_byte = BYTE_INVALID; // RQ16
        if (cls_q == CLS_READ) begin
            data_byte = rd_data; // RQ17 RQ10
        end else if (cls_q == CLS_WRITE || cls_q == CLS_CLEAR) begin
            data_byte = BYTE_WRITE; // RQ18 RQ11
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 1'b0;
            oe_b_q <= 1'b1;
            tx_q <= '0;
        end else if (!sel_act || rst5_act) begin
            oe_b_q <= 1'b1; // RQ3 RQ7
            out_q <= 1'b0;
        end else if (sck_rise) begin
            // Only address-matched frames drive; chip address bits float
            oe_b_q <= (cnt_q < CNT_ADDR_BITS) || !addr_ok_q; // RQ20 RQ19
            if (cnt_q < CNT_DATA_FIRST) begin
                out_q <= verif_byte[3'(~cnt_q[2:0])];
            end else if (cnt_q == CNT_DATA_FIRST) begin
                out_q <= data_byte[7];
                tx_q <= {data_byte[6:0], 1'b0};
            end else if (cnt_q < CNT_FRAME) begin
                out_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Remembers whether the flag bit went out in this frame
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sent_q <= 1'b0;
        end else if (!sel_act) begin
            sent_q <= 1'b0;
        end else if (sck_rise && cnt_q == CNT_INSTR_LAST && addr_ok_q
                     && !rst5_act) begin
            sent_q <= 1'b1; // RQ9
        end
    end

    // ==========================================================
    // End of frame
    // ==========================================================
    logic frame_err;
    logic par_ok;
    logic commit;

    assign frame_err = (cls_q == CLS_NONE) || busy_q
                       || (cnt_q != CNT_FRAME); // RQ13
    assign par_ok = (instr_q[0] == scp_parity(instr_q[5:1])); // RQ24
    assign commit = sel_rise && addr_ok_q && !frame_err && par_ok; // RQ14

    // An unsent flag survives: a new error ORs in, never lost
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= TRANS_FLAG_RST;
        end else if (sel_rise && addr_ok_q) begin
            flag_q <= frame_err | (flag_q & ~sent_q); // RQ9
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_stb <= 1'b0;
            wr_code <= CODE_RST;
            wr_data <= TXDATA_RST;
            clr_stb <= 1'b0;
        end else begin
            wr_stb <= commit && (cls_q == CLS_WRITE)
                      && !filt_q[I_SCK]; // RQ18 RQ15
            clr_stb <= commit && (cls_q == CLS_CLEAR); // RQ21
            if (commit) begin
                wr_code <= instr_q[5:1];
                wr_data <= shin_q[7:0];
            end
        end
    end

    assign reg_code = reg_code_q;
    assign err_flag = flag_q;
    assign spi.miso = out_q;
    assign spi.miso_oe_b = oe_b_q;

endmodule : scp_device

`default_nettype wire

// *** scp_host.sv ***
`default_nettype none

module scp_host (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    scp_spi_if.host spi
);
    import scp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEAD = 3'h1,
        ST_HIGH = 3'h3,
        ST_LOW = 3'h2,
        ST_TRAIL = 3'h6,
        ST_GAP = 3'h4
    } scp_state_e;

    localparam logic [7:0] HALF = 8'(SCK_HALF_CYC - 1);

    // ==========================================================
    // Miso synchroniser
    // ==========================================================
    logic m1_q;
    logic m2_q;
    logic m3_q;
    logic miso_f_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            m1_q <= 1'b0;
            m2_q <= 1'b0;
            m3_q <= 1'b0;
            miso_f_q <= 1'b0;
        end else begin
            m1_q <= spi.miso;
            m2_q <= m1_q;
            m3_q <= m2_q;
            if (m2_q == m3_q) begin
                miso_f_q <= m3_q;
            end
        end
    end

    // ==========================================================
    // Bus slave
    // ==========================================================
    scp_state_e st_q;
    logic wr_pend_q;
    logic [3:0] waddr_q;
    logic [4:0] code_q;
    logic badpar_q;
    logic [4:0] nbits_q;
    logic [7:0] txd_q;
    logic [7:0] verif_q;
    logic [7:0] rxd_q;
    logic clr_due_q;
    logic start;
    logic [31:0] rmux;

    always_comb begin
        rmux = '0;
        if (haddr[3:0] == REG_CTRL) begin
            rmux[CTRL_CODE_LSB +: 5] = code_q;
            rmux[CTRL_BADPAR_BIT] = badpar_q;
            rmux[CTRL_NBITS_LSB +: 5] = nbits_q;
        end else if (haddr[3:0] == REG_TXDATA) begin
            rmux[7:0] = txd_q;
        end else if (haddr[3:0] == REG_STATUS) begin
            rmux[STAT_BUSY_BIT] = (st_q != ST_IDLE);
            rmux[STAT_CLRDUE_BIT] = clr_due_q;
            rmux[STAT_VERIF_LSB +: 8] = verif_q;
            rmux[STAT_RXD_LSB +: 8] = rxd_q;
        end
    end

    // Zero wait states: read data is latched in the address phase
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            waddr_q <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                wr_pend_q <= hsel && htrans[1] && hwrite;
                waddr_q <= haddr[3:0];
                if (hsel && htrans[1] && !hwrite) begin
                    hrdata <= rmux;
                end
            end
        end
    end

    // Writes to the command registers are dropped during a frame
    assign start = wr_pend_q && waddr_q == REG_CTRL && st_q == ST_IDLE
                   && hwdata[CTRL_START_BIT];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            code_q <= CODE_RST;
            badpar_q <= 1'b0;
            nbits_q <= NBITS_RST;
            txd_q <= TXDATA_RST;
        end else if (wr_pend_q && st_q == ST_IDLE) begin
            if (waddr_q == REG_CTRL) begin
                code_q <= hwdata[CTRL_CODE_LSB +: 5];
                badpar_q <= hwdata[CTRL_BADPAR_BIT];
                nbits_q <= hwdata[CTRL_NBITS_LSB +: 5];
            end else if (waddr_q == REG_TXDATA) begin
                txd_q <= hwdata[7:0];
            end
        end
    end

    // ==========================================================
    // Frame engine
    // ==========================================================
    logic [7:0] div_q;
    logic [4:0] bitn_q;
    logic [FRAME_BITS-1:0] txsh_q;
    logic [FRAME_BITS-1:0] rxsh_q;
    logic sel_b_q;
    logic sck_q;
    logic mosi_q;
    logic [4:0] cur_code;
    logic [4:0] cur_nbits;

    assign cur_code = hwdata[CTRL_CODE_LSB +: 5];
    assign cur_nbits = hwdata[CTRL_NBITS_LSB +: 5];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            div_q <= '0;
            bitn_q <= '0;
            txsh_q <= '0;
            rxsh_q <= '0;
            sel_b_q <= 1'b1;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            verif_q <= '0;
            rxd_q <= '0;
        end else if (st_q == ST_IDLE) begin
            if (start) begin
                st_q <= ST_LEAD;
                div_q <= HALF;
                bitn_q <= '0;
                sel_b_q <= 1'b0;
                // Address 00, code, parity, then data MSB first
                txsh_q <= {CHIP_ADDR, cur_code, // RQ2 RQ4
                           scp_parity(cur_code) ^ hwdata[CTRL_BADPAR_BIT],
                           txd_q}; // RQ24
            end
        end else if (div_q != 8'h00) begin
            div_q <= div_q - 8'h01; // RQ1
        end else begin
            div_q <= HALF;
            case (st_q)
                ST_LEAD, ST_LOW: begin
                    if (bitn_q == nbits_q) begin
                        st_q <= ST_TRAIL;
                    end else begin
                        st_q <= ST_HIGH;
                        sck_q <= 1'b1;
                        mosi_q <= txsh_q[FRAME_BITS-1];
                        txsh_q <= {txsh_q[FRAME_BITS-2:0], 1'b0};
                    end
                end
                ST_HIGH: begin
                    st_q <= ST_LOW;
                    sck_q <= 1'b0;
                    rxsh_q <= {rxsh_q[FRAME_BITS-2:0], miso_f_q};
                    bitn_q <= bitn_q + 5'h01;
                end
                ST_TRAIL: begin
                    st_q <= ST_GAP;
                    sel_b_q <= 1'b1;
                    mosi_q <= 1'b0;
                    verif_q <= rxsh_q[15:8];
                    rxd_q <= rxsh_q[7:0];
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Reminder that fault registers were read and await clearing
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clr_due_q <= 1'b0;
        end else if (st_q == ST_TRAIL && div_q == 8'h00
                     && code_q >= CODE_DIAG_FIRST
                     && code_q <= CODE_DIAG_LAST) begin
            clr_due_q <= 1'b1; // RQ23
        end else if (start && cur_code == CODE_CLEAR_DIAG
                     && cur_nbits == NBITS_RST) begin
            clr_due_q <= 1'b0;
        end
    end

    assign spi.sel_b = sel_b_q;
    assign spi.sck = sck_q;
    assign spi.mosi = mosi_q;

endmodule : scp_host

`default_nettype wire

// *** scp_spi_sva.sv ***
`default_nettype none

module scp_spi_sva (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sel_b,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_b
);
    // ==========================================================
    // Link checks
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_float_desel: assert property (sel_b [*8] |-> miso_oe_b)
        else $error("serial output driven while deselected");
    a_addr_float: assert property ($fell(sel_b) |-> miso_oe_b [*8])
        else $error("serial output driven during chip address");
    a_sck_idle: assert property (sel_b [*2] |-> !sck)
        else $error("serial clock high outside a frame");
    a_sck_high: assert property ($rose(sck) |=> sck [*8])
        else $error("serial clock high phase too short");
    a_sck_low: assert property ($fell(sck) |=> !sck [*8])
        else $error("serial clock low phase too short");
    // Data may move with the rising clock or while it is low, never while it stands high
    a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("host data changed while clock high");
    a_sel_lead: assert property ($fell(sel_b) |-> !sck [*8])
        else $error("clock too soon after selection");
    a_desel_gap: assert property ($rose(sel_b) |=> sel_b [*8])
        else $error("deselect gap too short");
endmodule : scp_spi_sva

`default_nettype wire

// *** spi_slave_command_port_test.sv ***
`default_nettype none

module spi_slave_command_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import scp_pkg::*;
    logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, reset_5v_b;
    logic proc_busy, wr_stb, clr_stb, err_flag, st_vld, flag, due;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv, st_val;
    logic [7:0] rd_data, wr_data;
    logic [4:0] reg_code, wr_code;
    int num_errors, tests_run, seed;
    logic [20:0] st_q[$];
    logic [12:0] cm_q[$];
    scp_spi_if spi();

    scp_host scp_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .spi(spi.host));
    scp_device scp_device_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .spi(spi.device), .reset_5v_b(reset_5v_b), .proc_busy(proc_busy),
        .rd_data(rd_data), .reg_code(reg_code), .wr_stb(wr_stb),
        .wr_code(wr_code), .wr_data(wr_data), .clr_stb(clr_stb),
        .err_flag(err_flag));
    scp_spi_sva scp_spi_sva_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .sel_b(spi.sel_b), .sck(spi.sck), .mosi(spi.mosi),
        .miso(spi.miso), .miso_oe_b(spi.miso_oe_b));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic end_sim;
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // One AHB single transfer; a 99-cycle limit in the task ends a stuck wait
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] wd);
        int i;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {28'h0000000, a};
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (hreadyout !== 1'b1 && i < 99);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk_sys);
            i++;
        end while (hreadyout !== 1'b1 && i < 99);
        rdv = hrdata;
        if (i >= 99) begin
            num_errors++;
            end_sim();
        end
    endtask : bus

    task automatic frame(input logic [4:0] c, input logic bp,
                         input logic [4:0] nb, input logic chk);
        logic [7:0] d, ans;
        logic inv, bad;
        int i;
        d = 8'($random(seed));
        rd_data <= d;
        inv = !(c <= 5'h0F || (c >= 5'h11 && c <= 5'h18));
        ans = inv ? 8'hFF : ((c <= 5'h0F) ? d : 8'h00);
        bus(1'b1, REG_TXDATA, {24'h000000, d});
        bus(1'b1, REG_CTRL, {1'b1, 20'h00000, nb, bp, c});
        bad = inv || nb != 5'h10 || proc_busy;
        if (!bad && !bp && c >= 5'h11)
            cm_q.push_back({c, (c == 5'h18) ? 8'h00 : d});
        i = 0;
        while (spi.sel_b !== 1'b0 && i < 99) begin
            @(posedge clk_sys);
            i++;
        end
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            i++;
        end while (rdv[0] !== 1'b0 && i < 999);
        if (i >= 999) begin
            num_errors++;
            end_sim();
        end
        if (c == 5'h18 && nb == 5'h10)
            due = 1'b0;
        if (c >= 5'h08 && c <= 5'h0C)
            due = 1'b1;
        if (chk) begin
            st_q.push_back({ans, 5'h15, flag, bad, c, due});
            st_val <= rdv;
            st_vld <= 1'b1;
            @(posedge clk_sys);
            st_vld <= 1'b0;
        end
        flag = bad;
    endtask : frame

    // ==========================================================
    // Result watcher
    // ==========================================================
    always @(posedge clk_sys) begin
        if (st_vld === 1'b1)
            cmp("status", st_q.pop_front(),
                {st_val[23:16], st_val[13:8], err_flag, reg_code, st_val[1]});
        if (wr_stb === 1'b1)
            cmp("write", cm_q.pop_front(), {wr_code, wr_data});
        if (clr_stb === 1'b1)
            cmp("clear", cm_q.pop_front(), {5'h18, 8'h00});
        if (reset_5v_b === 1'b0)
            cmp("float", 1, spi.miso_oe_b);
    end

    initial begin
        seed = 32'h541A8E3C;
        {rst_b, hsel, htrans, haddr, hwrite, hwdata} = '0;
        {proc_busy, rd_data, st_vld, st_val, flag, due} = '0;
        reset_5v_b = 1'b1;
        num_errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int k = 0; k < 32; k++)
            frame(5'(k), 1'b0, 5'h10, 1'b1);
        frame(5'h12, 1'b1, 5'h10, 1'b1);
        frame(5'h03, 1'b1, 5'h10, 1'b1);
        frame(5'h14, 1'b0, 5'h0F, 1'b0);
        frame(5'h06, 1'b0, 5'h10, 1'b1);
        frame(5'h15, 1'b0, 5'h11, 1'b0);
        frame(5'h11, 1'b0, 5'h10, 1'b1);
        proc_busy <= 1'b1;
        frame(5'h16, 1'b0, 5'h10, 1'b0);
        proc_busy <= 1'b0;
        frame(5'h0B, 1'b0, 5'h10, 1'b1);
        reset_5v_b <= 1'b0;
        frame(5'h05, 1'b0, 5'h10, 1'b0);
        reset_5v_b <= 1'b1;
        frame(5'h17, 1'b0, 5'h10, 1'b1);
        repeat (20) @(posedge clk_sys);
        cmp("pending", 0, cm_q.size());
        end_sim();
    end
endmodule : spi_slave_command_port_test

`default_nettype wire
